/* File: board_memory_io_decode_ack.sv */
// Board memory and I/O decode with internal acknowledge, shared RAM arbiter and reset.
// Assumes the CPU side is on the board clock; system-bus and strap pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module board_memory_io_decode_ack
  import bmd_pkg::*;
#(
  parameter int TIMEOUT_CYC = bmd_pkg::TIMEOUT_CYC,
  parameter logic [19:0] EXT_BASE = 20'h00000
) (
  // Clock, reset and enable
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Board straps and pushbutton (asynchronous)
  input wire logic timer_en_i,
  input wire logic [1:0] rom_cfg_i,
  input wire logic [1:0] ext_win_i,
  input wire logic reset_btn_n_i,
  // Processor cycle (board clock)
  input wire logic cpu_start_i,
  input wire logic [19:0] cpu_addr_i,
  input wire logic cpu_io_i,
  input wire logic cpu_wr_i,
  output logic cpu_ready_o,
  output logic timeout_n_o,
  output logic cpu_reset_o,
  // Memory and peripheral selects
  output logic ram_cpu_sel_o,
  output logic rom_sel_o,
  output logic pic_sel_o,
  output logic ppi_sel_o,
  output logic pit_sel_o,
  output logic uart_sel_o,
  output logic [1:0] io_reg_o,
  // Peripheral resets
  output logic uart_reset_o,
  output logic ppi_reset_o,
  // System bus as master (asynchronous inputs)
  input wire logic bus_grant_i,
  input wire logic xack_n_i,
  output logic bus_req_o,
  output logic bus_cmd_o,
  output logic bus_init_o,
  // System bus as slave to the shared RAM (asynchronous inputs)
  input wire logic ext_cmd_n_i,
  input wire logic [19:1] ext_addr_i,
  input wire logic ext_adr0_n_i,
  input wire logic ext_bhen_n_i,
  output logic ext_ack_o,
  output logic ram_ext_sel_o,
  output logic even_oe_o,
  output logic odd_oe_o,
  output logic swap_oe_o
);
  import bmd_pkg::*;

  localparam int SW = 2 + 2 + 2 + 1 + 2 + 19 + 2; // Width of the synchronised pin group
  localparam int RW = $clog2(RESET_HOLD_CYC + 1);
  localparam logic [RW-1:0] RST_LAST = RW'(RESET_HOLD_CYC - 1);
  localparam int SLW = $clog2(RAM_SLOT_CYC + 1);
  localparam logic [SLW-1:0] SLOT_LAST = SLW'(RAM_SLOT_CYC - 1);

  // Two-flop synchroniser for every asynchronous pin
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] meta_reg; // First stage, read only by the second
  logic [SW-1:0] sync_reg; // Safe to use
  assign pin_raw = {timer_en_i, reset_btn_n_i, rom_cfg_i, ext_win_i, bus_grant_i, xack_n_i, ext_cmd_n_i,
                    ext_addr_i, ext_adr0_n_i, ext_bhen_n_i};

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= {2'b01, {(SW-2){1'b1}}};
      sync_reg <= {2'b01, {(SW-2){1'b1}}};
    end else if (clk_en_i) begin
      meta_reg <= pin_raw;
      sync_reg <= meta_reg;
    end
  end

  // Named views of the synchronised pins
  logic s_timer_en, s_btn_n, s_grant, s_xack_n, s_ext_cmd_n, s_adr0_n, s_bhen_n;
  logic [1:0] s_rom_cfg, s_ext_win;
  logic [19:1] s_ext_addr;
  assign {s_timer_en, s_btn_n, s_rom_cfg, s_ext_win, s_grant, s_xack_n, s_ext_cmd_n,
          s_ext_addr, s_adr0_n, s_bhen_n} = sync_reg;

  // Board reset: stretched after power-up and after button release alike
  logic [RW-1:0] rst_cnt_reg; // Hold counter
  logic board_rst_reg;        // Board reset level

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rst_cnt_reg <= '0;
      board_rst_reg <= 1'b1;
    end else if (clk_en_i) begin
      if (!s_btn_n) begin
        // Button held: restart the same sequence power-up uses
        rst_cnt_reg <= '0;
        board_rst_reg <= 1'b1;
      end else if (board_rst_reg) begin
        if (rst_cnt_reg == RST_LAST) begin
          board_rst_reg <= 1'b0;
        end else begin
          rst_cnt_reg <= rst_cnt_reg + 1'b1;
        end
      end
    end
  end

  // Reset fan-out; timer and interrupt controller deliberately get none
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cpu_reset_o <= 1'b1;
      bus_init_o <= 1'b1;
      uart_reset_o <= 1'b1;
      ppi_reset_o <= 1'b1;
    end else if (clk_en_i) begin
      cpu_reset_o <= board_rst_reg;
      bus_init_o <= board_rst_reg;
      uart_reset_o <= board_rst_reg;
      ppi_reset_o <= board_rst_reg;
    end
  end

  // Processor address decode
  logic [19:0] rom_low;  // Lowest populated ROM address
  logic hit_ram, hit_rom, hit_rom_legal;
  logic hit_pic, hit_ppi, hit_pit, hit_uart, hit_io_on;
  logic [7:0] io_blk;

  always_comb begin
    case (s_rom_cfg)
      2'h0: rom_low = ROM_LOW_CFG0;
      2'h1: rom_low = ROM_LOW_CFG1;
      2'h2: rom_low = ROM_LOW_CFG2;
      default: rom_low = ROM_LOW_CFG3;
    endcase
  end

  assign hit_ram = !cpu_io_i && cpu_addr_i <= RAM_TOP;
  // The whole socket area is acknowledged; only the populated part is selected
  assign hit_rom = !cpu_io_i && cpu_addr_i >= ROM_DECODE_LOW;
  assign hit_rom_legal = hit_rom && cpu_addr_i >= rom_low;
  // Upper address bits ignored; odd addresses select nothing
  assign io_blk = cpu_addr_i[7:0] & IO_BLOCK_MASK;
  assign hit_pic = cpu_io_i && !cpu_addr_i[0] && io_blk == IO_PIC_BASE;
  assign hit_ppi = cpu_io_i && !cpu_addr_i[0] && io_blk == IO_PPI_BASE;
  assign hit_pit = cpu_io_i && !cpu_addr_i[0] && io_blk == IO_PIT_BASE;
  assign hit_uart = cpu_io_i && !cpu_addr_i[0] && io_blk == IO_UART_BASE;
  assign hit_io_on = hit_pic || hit_ppi || hit_pit || hit_uart;

  // Processor cycle sequencer
  bmd_state_t state_reg;
  bmd_state_t state_next;
  logic cpu_ram_gnt;  // Arbiter grant to the processor this cycle
  logic cpu_slot_end; // Processor RAM slot finishing
  logic expired;      // Failsafe expiry pulse

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BMD_IDLE: begin
        if (cpu_start_i) begin
          if (hit_ram) state_next = BMD_RAM;
          // ROM and I/O never go near the arbiter
          else if (hit_rom || hit_io_on) state_next = BMD_WAIT;
          else state_next = BMD_BREQ;
        end
      end
      BMD_WAIT: state_next = BMD_IDLE;
      BMD_RAM: if (cpu_slot_end) state_next = BMD_IDLE;
      BMD_BREQ: begin
        if (expired) state_next = BMD_IDLE;
        // The last cycle's acknowledge must have cleared, or a stale XACK would end this one
        else if (s_grant && s_xack_n) state_next = BMD_BCMD;
      end
      BMD_BCMD: begin
        if (expired || !s_xack_n) state_next = BMD_IDLE;
      end
      BMD_HANG: state_next = BMD_HANG;
      default: state_next = BMD_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= BMD_IDLE;
    end else if (clk_en_i) begin
      if (board_rst_reg) state_reg <= BMD_IDLE;
      else state_reg <= state_next;
    end
  end

  // Ready pulse: internal for on-board targets, XACK or expiry otherwise
  logic ready_next;
  assign ready_next = !board_rst_reg &&
                      ((state_reg == BMD_WAIT) || (state_reg == BMD_RAM && cpu_slot_end) ||
                       ((state_reg == BMD_BREQ || state_reg == BMD_BCMD) && expired) ||
                       (state_reg == BMD_BCMD && !s_xack_n));

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cpu_ready_o <= 1'b0;
      timeout_n_o <= 1'b1;
    end else if (clk_en_i) begin
      cpu_ready_o <= ready_next;
      timeout_n_o <= !expired;
    end
  end

  // System bus master handshake
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_req_o <= 1'b0;
      bus_cmd_o <= 1'b0;
    end else if (clk_en_i) begin
      bus_req_o <= state_next == BMD_BREQ || state_next == BMD_BCMD;
      bus_cmd_o <= state_next == BMD_BCMD;
    end
  end

  // Selects latched at cycle start and held for the cycle
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rom_sel_o <= 1'b0;
      pic_sel_o <= 1'b0;
      ppi_sel_o <= 1'b0;
      pit_sel_o <= 1'b0;
      uart_sel_o <= 1'b0;
      io_reg_o <= 2'h0;
    end else if (clk_en_i) begin
      if (state_reg == BMD_IDLE && cpu_start_i) begin
        rom_sel_o <= hit_rom_legal;
        pic_sel_o <= hit_pic;
        ppi_sel_o <= hit_ppi;
        pit_sel_o <= hit_pit;
        uart_sel_o <= hit_uart;
        // Bit 2 ignored for the two-register chips so aliases match
        io_reg_o <= (hit_pic || hit_uart) ? {1'b0, cpu_addr_i[1]} : cpu_addr_i[2:1];
      end else if (state_next == BMD_IDLE) begin
        rom_sel_o <= 1'b0;
        pic_sel_o <= 1'b0;
        ppi_sel_o <= 1'b0;
        pit_sel_o <= 1'b0;
        uart_sel_o <= 1'b0;
      end
    end
  end

  // External RAM request: window check, one access per command
  logic [19:0] ext_off;
  logic [19:0] ext_size;
  logic ext_hit;
  logic ext_served_reg; // Access done, waiting for command release
  assign ext_off = {s_ext_addr, 1'b0} - EXT_BASE;
  assign ext_size = EXT_WIN_STEP * (20'(s_ext_win) + 20'h1);
  assign ext_hit = !s_ext_cmd_n && ext_off < ext_size;

  // Arbiter: one slot at a time, alternating when both wait
  logic slot_busy_reg;       // Slot in progress
  logic slot_ext_reg;        // Slot owner is the bus master
  logic last_ext_reg;        // Last slot went to the bus master
  logic [SLW-1:0] slot_cnt_reg;
  logic cpu_pend, ext_pend, pick_ext;
  assign cpu_pend = state_reg == BMD_RAM && !cpu_ram_gnt;
  assign ext_pend = ext_hit && !ext_served_reg && !(slot_busy_reg && slot_ext_reg);
  assign pick_ext = ext_pend && (!cpu_pend || !last_ext_reg);
  assign cpu_ram_gnt = slot_busy_reg && !slot_ext_reg;
  assign cpu_slot_end = cpu_ram_gnt && slot_cnt_reg == SLOT_LAST;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      slot_busy_reg <= 1'b0;
      slot_ext_reg <= 1'b0;
      last_ext_reg <= 1'b0;
      slot_cnt_reg <= '0;
    end else if (clk_en_i) begin
      if (slot_busy_reg) begin
        if (slot_cnt_reg == SLOT_LAST) slot_busy_reg <= 1'b0;
        else slot_cnt_reg <= slot_cnt_reg + 1'b1;
      end else if (cpu_pend || ext_pend) begin
        // Slots interleave instead of one side holding the RAM
        slot_busy_reg <= 1'b1;
        slot_ext_reg <= pick_ext;
        last_ext_reg <= pick_ext;
        slot_cnt_reg <= '0;
      end
    end
  end

  // Bus slave acknowledge held until the master drops its command
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_served_reg <= 1'b0;
      ext_ack_o <= 1'b0;
    end else if (clk_en_i) begin
      if (s_ext_cmd_n) begin
        ext_served_reg <= 1'b0;
        ext_ack_o <= 1'b0;
      end else if (slot_busy_reg && slot_ext_reg && slot_cnt_reg == SLOT_LAST) begin
        ext_served_reg <= 1'b1;
        ext_ack_o <= 1'b1;
      end
    end
  end

  // RAM selects and byte lane steering
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ram_cpu_sel_o <= 1'b0;
      ram_ext_sel_o <= 1'b0;
      even_oe_o <= 1'b0;
      odd_oe_o <= 1'b0;
      swap_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      ram_cpu_sel_o <= cpu_ram_gnt;
      ram_ext_sel_o <= slot_busy_reg && slot_ext_reg;
      // Even bank on low lines, odd bank on high lines (or swapped low)
      even_oe_o <= slot_busy_reg && slot_ext_reg && !s_adr0_n;
      odd_oe_o <= slot_busy_reg && slot_ext_reg && !s_bhen_n;
      swap_oe_o <= slot_busy_reg && slot_ext_reg && s_adr0_n && s_bhen_n;
    end
  end

  // Failsafe timer
  bmd_timer_if tif ();
  assign tif.ce = clk_en_i;
  assign tif.enable = s_timer_en;
  assign tif.restart = state_reg == BMD_IDLE && cpu_start_i && !board_rst_reg;
  assign tif.ack = ready_next;
  assign expired = tif.expired;

  bmd_ack_timer #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_timer (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .tif(tif.timer)
  );

  // Checks
  rom_one_wait_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    clk_en_i && state_reg == BMD_IDLE && cpu_start_i && hit_rom && !board_rst_reg ##1 clk_en_i
    |=> cpu_ready_o) else $error("on-board ack not after one wait");
  io_never_stalls_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    clk_en_i && state_reg == BMD_IDLE && cpu_start_i && hit_io_on && !board_rst_reg
    |=> state_reg == BMD_WAIT) else $error("I/O cycle stalled");
  swap_lane_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    swap_oe_o |-> !even_oe_o && !odd_oe_o) else $error("swap buffer clashes with lanes");
  ext_window_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    clk_en_i && !slot_busy_reg && pick_ext |-> ext_off / EXT_WIN_STEP <= 20'(s_ext_win))
    else $error("bus master served outside window");
  grant_alternate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    clk_en_i && !slot_busy_reg && cpu_pend && ext_pend && last_ext_reg |=> slot_busy_reg && !slot_ext_reg)
    else $error("arbiter did not alternate");
  bus_cmd_after_grant_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(bus_cmd_o) |-> bus_req_o && $past(s_grant)) else $error("command without bus ownership");
  timeout_pulse_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $fell(timeout_n_o) |=> timeout_n_o || !clk_en_i) else $error("timeout output not a pulse");
  io_odd_illegal_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    cpu_io_i && cpu_addr_i[0] |-> !hit_io_on) else $error("odd I/O address selected");
  reset_to_bus_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    clk_en_i && !s_btn_n ##1 clk_en_i |=> bus_init_o && uart_reset_o && ppi_reset_o)
    else $error("button reset not propagated");

endmodule : board_memory_io_decode_ack
`default_nettype wire

/* File: bmd_pkg.sv */
// Constants, address maps and state codes for the board memory and I/O decode block.
// Assumes a single 20 MHz board clock; the timeout and reset hold counts below are derived from it.
package bmd_pkg;

  // Board clock rate and the failsafe acknowledge time
  localparam int CLK_HZ = 20_000_000;
  localparam int TIMEOUT_MS = 6;
  // Longest time, so the cycle count rounds down
  localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;

  // Board reset stretch after power-up or pushbutton release
  localparam int RESET_HOLD_US = 5;
  localparam int RESET_HOLD_CYC = (CLK_HZ / 1_000_000) * RESET_HOLD_US;

  // Cycles one shared RAM access slot occupies
  localparam int RAM_SLOT_CYC = 2;

  // Processor memory map
  localparam logic [19:0] RAM_TOP = 20'h07fff;
  localparam logic [19:0] ROM_DECODE_LOW = 20'hfc000;
  localparam logic [19:0] ROM_LOW_CFG0 = 20'hff800;
  localparam logic [19:0] ROM_LOW_CFG1 = 20'hff000;
  localparam logic [19:0] ROM_LOW_CFG2 = 20'hfe000;
  localparam logic [19:0] ROM_LOW_CFG3 = 20'hfc000;
  localparam logic [19:0] BOOT_ADDR = 20'hffff0;

  // External window granularity (8K bytes per step)
  localparam logic [19:0] EXT_WIN_STEP = 20'h02000;

  // I/O decode: block of eight addresses per peripheral, low byte only
  localparam logic [7:0] IO_BLOCK_MASK = 8'hf8;
  localparam logic [7:0] IO_PIC_BASE = 8'hc0;
  localparam logic [7:0] IO_PPI_BASE = 8'hc8;
  localparam logic [7:0] IO_PIT_BASE = 8'hd0;
  localparam logic [7:0] IO_UART_BASE = 8'hd8;

  // Processor cycle sequencer states
  typedef enum logic [5:0] {
    BMD_IDLE = 6'b000001,
    BMD_WAIT = 6'b000010,
    BMD_RAM = 6'b000100,
    BMD_BREQ = 6'b001000,
    BMD_BCMD = 6'b010000,
    BMD_HANG = 6'b100000
  } bmd_state_t;

endpackage : bmd_pkg

/* File: bmd_timer_if.sv */
// Connection between the cycle sequencer and the failsafe acknowledge timer.
// Assumes both ends run on the board clock.
`timescale 1ns/1ps
`default_nettype none
interface bmd_timer_if;
  logic ce;      // Clock enable, freezes the timer
  logic enable;  // Failsafe option strap, synchronised
  logic restart; // Start of a machine cycle
  logic ack;     // Cycle acknowledged, stop counting
  logic expired; // One-cycle expiry pulse

  modport timer (input ce, input enable, input restart, input ack, output expired);
  modport ctrl (output ce, output enable, output restart, output ack, input expired);
endinterface : bmd_timer_if
`default_nettype wire

/* File: bmd_ack_timer.sv */
// Failsafe acknowledge timer: counts from each cycle start and pulses on expiry.
// Assumes restart and ack come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bmd_ack_timer #(
  parameter int TIMEOUT_CYC = 120000
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Sequencer side
  bmd_timer_if.timer tif
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);

  logic [CW-1:0] count_reg; // Cycles since restart
  logic armed_reg;          // Counting a live cycle
  logic expired_reg;        // Expiry pulse

  assign tif.expired = expired_reg;

  // Restart wins over everything so each cycle gets its full time
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_reg <= '0;
      armed_reg <= 1'b0;
      expired_reg <= 1'b0;
    end else if (tif.ce) begin
      expired_reg <= 1'b0;
      if (tif.restart) begin
        count_reg <= '0;
        armed_reg <= 1'b1;
      end else if (tif.ack || !tif.enable) begin
        // A disabled timer never fires, leaving the cycle waiting
        armed_reg <= 1'b0;
      end else if (armed_reg) begin
        if (count_reg == LAST) begin
          expired_reg <= 1'b1;
          armed_reg <= 1'b0;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end

  // Expiry only after the full count with the option on
  property p_expiry;
    @(posedge ref_clk_i) disable iff (reset_i)
      $rose(expired_reg) |-> $past(tif.enable) && $past(count_reg) == LAST;
  endproperty
  timer_expiry_a: assert property (p_expiry) else $error("timer fired early");

  // A restart clears the count
  restart_clears_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    tif.restart && tif.ce |=> count_reg == '0 && armed_reg) else $error("restart ignored");

endmodule : bmd_ack_timer
`default_nettype wire

/* File: bmd_bus_partner.sv */
// System bus far side: an arbiter and one addressed slave.
// Assumes the board clock; answers change just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module bmd_bus_partner (
  // Clock and fault control
  input wire logic ref_clk_i,
  input wire logic mute_i,
  // Board requests
  input wire logic bus_req_i,
  input wire logic bus_cmd_i,
  // Answers
  output logic bus_grant_o,
  output logic xack_n_o
);
  logic [1:0] gnt_dly = 2'h0; // Grant lags request
  logic [2:0] ack_dly = 3'h0; // Slave is slow to answer
  // Delays model a busy arbiter and a slow slave
  always @(posedge ref_clk_i) begin
    gnt_dly <= {gnt_dly[0], bus_req_i};
    ack_dly <= bus_cmd_i ? {ack_dly[1:0], 1'b1} : 3'h0;
  end
  assign bus_grant_o = gnt_dly[1] & bus_req_i;
  // Pulled-up line, so a released or muted slave reads high
  assign xack_n_o = ~(ack_dly[2] & ~mute_i);
endmodule : bmd_bus_partner
`default_nettype wire

/* File: tb_board_memory_io_decode_ack.sv */
// Self-checking bench for the board decode and acknowledge block.
// Assumes the bus partner model; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_board_memory_io_decode_ack;
  import bmd_pkg::*;
  localparam int TMO = 50; // Short failsafe time keeps the run brief
  int bad_count = 0;
  int comparisons = 0;
  int n;
  logic ok, mute = 0;
  logic [2:0] f;
  logic [2:0] ln;
  logic [6:0] s;
  logic ref_clk_i = 0, reset_i = 1, timer_en_i = 1, cpu_start_i = 0, cpu_io_i = 0, cpu_wr_i = 0;
  logic reset_btn_n_i = 1, ext_cmd_n_i = 1, ext_adr0_n_i = 1, ext_bhen_n_i = 1;
  logic [1:0] rom_cfg_i = 2'h0, ext_win_i = 2'h0, io_reg_o;
  logic [19:0] cpu_addr_i = 20'h0;
  logic [19:1] ext_addr_i = 19'h0;
  logic cpu_ready_o, timeout_n_o, cpu_reset_o, ram_cpu_sel_o, rom_sel_o, pic_sel_o, ppi_sel_o;
  logic pit_sel_o, uart_sel_o, uart_reset_o, ppi_reset_o, bus_grant_i, xack_n_i, bus_req_o;
  logic bus_cmd_o, bus_init_o, ext_ack_o, ram_ext_sel_o, even_oe_o, odd_oe_o, swap_oe_o;
  board_memory_io_decode_ack #(.TIMEOUT_CYC(TMO)) dut (.ref_clk_i, .reset_i, .clk_en_i(1'b1),
    .timer_en_i, .rom_cfg_i, .ext_win_i, .reset_btn_n_i, .cpu_start_i, .cpu_addr_i, .cpu_io_i,
    .cpu_wr_i, .cpu_ready_o, .timeout_n_o, .cpu_reset_o, .ram_cpu_sel_o, .rom_sel_o, .pic_sel_o,
    .ppi_sel_o, .pit_sel_o, .uart_sel_o, .io_reg_o, .uart_reset_o, .ppi_reset_o, .bus_grant_i,
    .xack_n_i, .bus_req_o, .bus_cmd_o, .bus_init_o, .ext_cmd_n_i, .ext_addr_i, .ext_adr0_n_i,
    .ext_bhen_n_i, .ext_ack_o, .ram_ext_sel_o, .even_oe_o, .odd_oe_o, .swap_oe_o);
  bmd_bus_partner far (.ref_clk_i, .mute_i(mute), .bus_req_i(bus_req_o), .bus_cmd_i(bus_cmd_o),
    .bus_grant_o(bus_grant_i), .xack_n_o(xack_n_i));
  // Board clock, 50 ns period
  initial forever #25 ref_clk_i = ~ref_clk_i;
  task ticks(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask : ticks
  // One CPU cycle; n counts edges to ready, s holds selects after the first
  task automatic cyc(input logic [19:0] a, input logic io, input int lim, output int n,
    output logic [6:0] s, output logic [2:0] f);
    cpu_addr_i = a;
    cpu_io_i = io;
    cpu_wr_i = a[0];
    cpu_start_i = 1;
    @(negedge ref_clk_i);
    cpu_start_i = 0;
    // The start edge is the first; selects drop with ready, so look while they stand
    n = 1;
    s = {rom_sel_o, pic_sel_o, ppi_sel_o, pit_sel_o, uart_sel_o, io_reg_o};
    f = {ram_cpu_sel_o === 1'b1, bus_req_o === 1'b1, timeout_n_o === 1'b0};
    while (cpu_ready_o !== 1'b1 && n < lim) begin
      @(negedge ref_clk_i);
      n++;
      f = f | {ram_cpu_sel_o === 1'b1, bus_req_o === 1'b1, timeout_n_o === 1'b0};
    end
  endtask : cyc
  // One bus master access; command held until acked or 30 cycles pass, then released
  task automatic ext(input logic [19:0] a, input logic a0n, bhn, output logic ok, output logic [2:0] ln);
    int k;
    ext_addr_i = a[19:1];
    ext_adr0_n_i = a0n;
    ext_bhen_n_i = bhn;
    ext_cmd_n_i = 0;
    ok = 0;
    ln = 3'h0;
    for (k = 0; k < 30 && !ok; k++) begin
      @(negedge ref_clk_i);
      if (ram_ext_sel_o === 1'b1) ln = {even_oe_o, odd_oe_o, swap_oe_o};
      ok = (ext_ack_o === 1'b1);
    end
    ext_cmd_n_i = 1;
    for (k = 0; k < 30 && ext_ack_o !== 1'b0; k++) @(negedge ref_clk_i);
    ticks(1);
  endtask : ext
  task t_reset;
    `CHK("resets on", 4'hf, {cpu_reset_o, bus_init_o, uart_reset_o, ppi_reset_o})
    reset_i = 0;
    for (int k = 0; k < 150 && cpu_reset_o !== 1'b0; k++) ticks(1);
    `CHK("resets off", 4'h0, {cpu_reset_o, bus_init_o, uart_reset_o, ppi_reset_o})
    $display("reset test done");
  endtask : t_reset
  task t_rom;
    logic [19:0] lo[4];
    lo = '{ROM_LOW_CFG0, ROM_LOW_CFG1, ROM_LOW_CFG2, ROM_LOW_CFG3};
    for (int c = 0; c < 4; c++) begin
      rom_cfg_i = c[1:0];
      ticks(4);
      cyc(lo[c], 0, 10, n, s, f);
      `CHK("rom sel", 1'b1, s[6])
      `CHK("rom wait", 2, n)
      if (c < 3) begin
        cyc(lo[c] - 20'h1, 0, 10, n, s, f);
        `CHK("hole sel", 1'b0, s[6])
        `CHK("hole ack", 2, n)
      end
    end
    cyc(BOOT_ADDR, 0, 10, n, s, f);
    `CHK("boot sel", 1'b1, s[6])
    $display("rom test done");
  endtask : t_rom
  task t_io;
    logic [7:0] a;
    for (int i = 0; i < 16; i++) begin
      a = 8'hc0 + 8'(2 * i);
      cyc({12'h3f0, a}, 1, 10, n, s, f);
      `CHK("io sel", 4'h8 >> a[4:3], s[5:2])
      `CHK("io reg", (a[3] ^ a[4]) ? a[2:1] : {1'b0, a[1]}, s[1:0])
      `CHK("io wait", 2, n)
    end
    cyc(20'h000c1, 1, 40, n, s, f);
    `CHK("odd io", 6'h20, {f[1], s[6:2]})
    $display("io test done");
  endtask : t_io
  task t_mem;
    cyc(RAM_TOP, 0, 40, n, s, f);
    `CHK("ram local", 3'h5, {f[2:1], n >= 4 && n < 40})
    cyc(RAM_TOP + 20'h1, 0, 40, n, s, f);
    `CHK("off board", 3'h3, {f[2:1], n < 40})
    // Back to back: the previous acknowledge must not end the new cycle
    cyc(RAM_TOP + 20'h1, 0, 40, n, s, f);
    `CHK("back to back", 1'b1, n >= 8 && n < 40)
    $display("memory test done");
  endtask : t_mem
  task t_ext;
    logic [19:0] ad[4];
    logic [2:0] le[4];
    ad = '{20'h00010, 20'h00011, 20'h00012, 20'h00013};
    le = '{3'h6, 3'h2, 3'h4, 3'h1};
    for (int i = 0; i < 4; i++) begin
      ext(ad[i], ad[i][0], i[1], ok, ln);
      `CHK("lanes", {1'b1, le[i]}, {ok, ln})
    end
    ext(20'h02000, 0, 0, ok, ln);
    `CHK("outside 8k", 1'b0, ok)
    ext(BOOT_ADDR, 0, 0, ok, ln);
    `CHK("rom by bus", 1'b0, ok)
    ext_win_i = 2'h3;
    ticks(4);
    ext(20'h07ffe, 0, 0, ok, ln);
    `CHK("inside 32k", 1'b1, ok)
    fork
      ext(20'h00100, 0, 0, ok, ln);
      cyc(20'h00100, 0, 40, n, s, f);
    join
    `CHK("shared", 2'h3, {ok, n < 40})
    fork
      ext(20'h00200, 0, 0, ok, ln);
      cyc(BOOT_ADDR, 0, 10, n, s, f);
    join
    `CHK("rom beside bus", 2, n)
    $display("bus master test done");
  endtask : t_ext
  task t_hang;
    mute = 1;
    repeat (2) begin
      cyc(20'h40000, 0, 200, n, s, f);
      `CHK("expiry", 2'h3, {f[0], n >= TMO && n <= TMO + 3})
    end
    timer_en_i = 0;
    ticks(4);
    cyc(20'h40000, 0, 300, n, s, f);
    `CHK("hang", 2'h0, {f[0], n < 300})
    reset_btn_n_i = 0;
    ticks(4);
    `CHK("button on", 4'hf, {cpu_reset_o, bus_init_o, uart_reset_o, ppi_reset_o})
    reset_btn_n_i = 1;
    for (int k = 0; k < 150 && cpu_reset_o !== 1'b0; k++) ticks(1);
    `CHK("button off", 1'b0, cpu_reset_o)
    mute = 0;
    cyc(BOOT_ADDR, 0, 10, n, s, f);
    `CHK("freed", 2, n)
    $display("failsafe test done");
  endtask : t_hang
  task report_and_stop;
    $display("checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // Main sequence, reset held for ten cycles
  initial begin
    ticks(10);
    t_reset;
    t_rom;
    t_io;
    t_mem;
    t_ext;
    t_hang;
    report_and_stop;
  end
  // Watchdog at 40000 cycles, well beyond the fewer than a thousand cycles the tests need
  initial begin
    #2_000_000;
    bad_count++;
    report_and_stop;
  end
endmodule : tb_board_memory_io_decode_ack
`default_nettype wire
